// [hw/pwr_irq_pkg.sv]
package pwr_irq_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PWR_MODE   = 8'h00;  // power_mode_control
  localparam logic [7:0] OFF_IRQ_FLAGS  = 8'h04;  // interrupt_request_flags_1
  localparam logic [7:0] OFF_AUX_CTRL   = 8'h08;  // noise select, timer a enable
  localparam logic [7:0] OFF_EVT_STATUS = 8'h0C;  // sticky event status
  localparam logic [7:0] OFF_EVT_MASK   = 8'h10;  // event mask
  localparam logic [7:0] OFF_STATE      = 8'h14;  // power state, read only

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_STANDBY_SEL = 7;
  localparam int BIT_WAIT_HI     = 6;
  localparam int BIT_WAIT_LO     = 4;
  localparam int BIT_LOW_SPEED   = 3;
  localparam int BIT_TA_FLAG     = 7;
  localparam int BIT_S1_FLAG     = 6;
  localparam int BIT_NOISE_SEL   = 0;
  localparam int BIT_TA_IEN      = 1;

  // ----------------------------------------------------------------
  // reset values; unused bits read as one
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PWR_MODE  = 8'h07;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h20;
  localparam logic [7:0] PWR_FIXED_ONE = 8'h07;
  localparam logic [7:0] IRQ_FIXED_ONE = 8'h20;
  localparam logic [7:0] IRQ_FLAG_MASK = 8'hDF;

  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam int unsigned WAIT_STATES_0 = 8192;
  localparam int unsigned WAIT_STATES_1 = 16384;
  localparam int unsigned WAIT_STATES_2 = 32768;
  localparam int unsigned WAIT_STATES_3 = 65536;
  localparam int unsigned WAIT_STATES_4 = 131072;
  localparam int unsigned NOISE_DIV_SLOW = 16;
  localparam int unsigned NOISE_DIV_FAST = 4;
  localparam int unsigned DIV_W          = 4;

  // ----------------------------------------------------------------
  // power states, gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACTIVE    = 3'h0,
    ST_SLEEP     = 3'h1,
    ST_STANDBY   = 3'h3,
    ST_WATCH     = 3'h2,
    ST_SUBACTIVE = 3'h6,
    ST_SUBSLEEP  = 3'h7
  } pwr_state_t;

  // hardware event sources
  typedef struct packed {
    logic       timer_a_tick;   // counter clock enable for timer a
    logic       serial1_done;   // serial channel 1 transfer complete
    logic [4:0] ext_pins;       // raw external pin levels
  } irq_src_t;

endpackage : pwr_irq_pkg

// [hw/edge_filter.sv]
`timescale 1ns/1ns
// ------------------------------------------------------------------
// sampled edge detector for the external interrupt pins
// ------------------------------------------------------------------
module edge_filter #(
  parameter int N = 5
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         sample_en,   // one-cycle sampling pulse
  input  wire logic [N-1:0] pins,        // pin levels
  input  wire logic [N-1:0] rising_sel,  // 1 = rising edge, 0 = falling
  output logic      [N-1:0] edge_seen    // one-cycle pulse per pin
);
  logic [N-1:0] s0_r;  // first sample
  logic [N-1:0] s1_r;  // previous sample

  // ----------------------------------------------------------------
  // two consecutive samples must agree before a level counts,
  // which drops glitches shorter than one sample period
  // ----------------------------------------------------------------
  logic [N-1:0] stable_r;  // filtered level

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s0_r     <= '0;
      s1_r     <= '0;
      stable_r <= '0;
      edge_seen <= '0;
    end else begin
      edge_seen <= '0;
      if (sample_en) begin
        s0_r <= pins;
        s1_r <= s0_r;
        for (int i = 0; i < N; i++) begin
          if (s0_r[i] == s1_r[i] && s0_r[i] != stable_r[i]) begin
            stable_r[i]  <= s0_r[i];
            edge_seen[i] <= (s0_r[i] == rising_sel[i]);
          end
        end
      end
    end
  end
endmodule : edge_filter

// [hw/pwr_irq_regs.sv]
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
// What this block does
// - sleep in active: standby bit picks sleep/standby
// - sleep in subactive: subsleep or watch
// - low-speed bit selects subclock for cpu
// - noise sampling at osc/16 or osc/4
// - pin flags cleared by writing zero
// - pin flag set on selected pin edge
// - serial1 flag set on done, zero clears
// - timer a flag cleared by writing zero
// - timer a flag set on counter wrap
// - timer a enable gates its interrupt
module pwr_irq_regs
  import pwr_irq_pkg::*;
#(
  parameter int unsigned WAIT_SCALE = 1  // divide waits for simulation
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        SLEEP_REQ,     // sleep instruction executed
  input  wire logic        WAKE_REQ,      // wake event from any source
  input  wire irq_src_t    SRC,           // hardware event sources
  input  wire logic [4:0]  PIN_IRQ_EN,    // pin configured as interrupt input
  input  wire logic [4:0]  PIN_RISING,    // edge select per pin
  output logic             CPU_ON_SUBCLK, // cpu runs on subclock
  output logic             WAIT_DONE,     // oscillator settling complete
  output logic             IRQ_TIMER_A,   // gated timer a interrupt
  output logic             IRQ            // summary event interrupt
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]  pwr_r;        // power_mode_control
  logic [7:0]  flags_r;      // interrupt_request_flags_1
  logic [1:0]  aux_r;        // noise select and timer a enable
  logic [7:0]  evt_r;        // sticky event status
  logic [7:0]  mask_r;       // event mask
  pwr_state_t  state_r;      // current power state
  pwr_state_t  state_nxt;    // next power state
  logic [17:0] wait_r;       // settling countdown
  logic [7:0]  tmr_r;        // timer a counter
  logic [3:0]  div_r;        // noise sample divider
  logic        sample_en;    // one-cycle sample pulse
  logic [4:0]  pin_edge;     // filtered pin edges

  // ----------------------------------------------------------------
  // apb decode; single-cycle access phase, always ready
  // ----------------------------------------------------------------
  logic wr_en;   // write takes effect
  logic rd_en;   // read data captured
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;

  // every mapped word; anything else answers with an error
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == OFF_PWR_MODE) || (a == OFF_IRQ_FLAGS) ||
                 (a == OFF_AUX_CTRL) || (a == OFF_EVT_STATUS) ||
                 (a == OFF_EVT_MASK) || (a == OFF_STATE);
  endfunction : known_addr

  // wait length from the three-bit field; top bit overrides
  function automatic logic [17:0] wait_len(input logic [2:0] sel);
    logic [17:0] n;
    n = 18'(WAIT_STATES_4);
    unique case (sel[1:0])
      2'h0:    n = sel[2] ? 18'(WAIT_STATES_4) : 18'(WAIT_STATES_0);
      2'h1:    n = sel[2] ? 18'(WAIT_STATES_4) : 18'(WAIT_STATES_1);
      2'h2:    n = sel[2] ? 18'(WAIT_STATES_4) : 18'(WAIT_STATES_2);
      2'h3:    n = sel[2] ? 18'(WAIT_STATES_4) : 18'(WAIT_STATES_3);
    endcase
    wait_len = 18'(n / WAIT_SCALE);
  endfunction : wait_len

  // ----------------------------------------------------------------
  // bus answer registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;  // ready in the access phase
      PSLVERR <= PSEL && !PENABLE && !known_addr(PADDR);
      // taken at the setup edge, so it stands through the access cycle
      if (rd_en) begin  // unmapped reads return zero
        unique case (PADDR)
          OFF_PWR_MODE:   PRDATA <= {24'h0, pwr_r | PWR_FIXED_ONE};
          OFF_IRQ_FLAGS:  PRDATA <= {24'h0, flags_r | IRQ_FIXED_ONE};
          OFF_AUX_CTRL:   PRDATA <= {30'h0, aux_r};
          OFF_EVT_STATUS: PRDATA <= {24'h0, evt_r};
          OFF_EVT_MASK:   PRDATA <= {24'h0, mask_r};
          OFF_STATE:      PRDATA <= {29'h0, state_r};
          default:        PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pwr_r  <= RST_PWR_MODE;
      aux_r  <= 2'h0;
      mask_r <= 8'h00;
    end else if (wr_en) begin
      if (PADDR == OFF_PWR_MODE) pwr_r <= PWDATA[7:0] | PWR_FIXED_ONE;
      if (PADDR == OFF_AUX_CTRL) aux_r <= PWDATA[1:0];
      if (PADDR == OFF_EVT_MASK) mask_r <= PWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // noise sampling divider; pulse period equals the divide ratio
  // ----------------------------------------------------------------
  logic [3:0] div_lim;  // last count of the current period
  assign div_lim = aux_r[BIT_NOISE_SEL] ? 4'(NOISE_DIV_FAST - 1)
                                        : 4'(NOISE_DIV_SLOW - 1);

  // a count above the limit, left from the slow rate, ends at once
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_r     <= 4'h0;
      sample_en <= 1'b0;
    end else begin
      sample_en <= (div_r >= div_lim);
      div_r     <= (div_r >= div_lim) ? 4'h0 : 4'(div_r + 4'h1);
    end
  end

  // pin edges, filtered at the divided sample rate
  edge_filter #(.N(5)) u_edge (
    .clk        (CLK),
    .rst        (RST),
    .sample_en  (sample_en),
    .pins       (SRC.ext_pins),
    .rising_sel (PIN_RISING),
    .edge_seen  (pin_edge)
  );

  // ----------------------------------------------------------------
  // timer a counter
  // ----------------------------------------------------------------
  logic tmr_wrap;  // counter goes from all ones to zero
  assign tmr_wrap = SRC.timer_a_tick && (tmr_r == 8'hFF);

  // the count rolls over silently; the flag and event status bit 7 record it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) tmr_r <= 8'h00;
    else if (SRC.timer_a_tick) tmr_r <= 8'(tmr_r + 8'h01);
  end

  // ----------------------------------------------------------------
  // request flags; a hardware set wins over a same-cycle clear
  // ----------------------------------------------------------------
  // bit 5 has no source and always reads as one
  logic [7:0] set_vec;  // hardware set events
  logic [7:0] clr_vec;  // software clears
  assign set_vec = {tmr_wrap, SRC.serial1_done, 1'b0,
                    pin_edge & PIN_IRQ_EN};
  // zero written over a one clears; ones written are ignored
  assign clr_vec = (wr_en && PADDR == OFF_IRQ_FLAGS) ?
                   (~PWDATA[7:0] & flags_r & IRQ_FLAG_MASK) : 8'h00;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) flags_r <= RST_IRQ_FLAGS;
    else flags_r <= ((flags_r & ~clr_vec) | set_vec) | IRQ_FIXED_ONE;
  end

  // ----------------------------------------------------------------
  // event status, write one to clear, mask gates the summary line
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      evt_r       <= 8'h00;
      IRQ         <= 1'b0;
      IRQ_TIMER_A <= 1'b0;
    end else begin
      evt_r <= (evt_r & ~((wr_en && PADDR == OFF_EVT_STATUS) ? PWDATA[7:0] : 8'h00))
               | set_vec;
      IRQ   <= |(evt_r & mask_r);
      IRQ_TIMER_A <= flags_r[BIT_TA_FLAG] && aux_r[BIT_TA_IEN];
    end
  end

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_ACTIVE:    if (SLEEP_REQ)
                      state_nxt = pwr_r[BIT_STANDBY_SEL] ? ST_STANDBY : ST_SLEEP;
      ST_SUBACTIVE: if (SLEEP_REQ)
                      state_nxt = pwr_r[BIT_STANDBY_SEL] ? ST_WATCH : ST_SUBSLEEP;
      ST_SLEEP:     if (WAKE_REQ) state_nxt = ST_ACTIVE;
      ST_SUBSLEEP:  if (WAKE_REQ) state_nxt = ST_SUBACTIVE;
      ST_STANDBY, ST_WATCH:
                    if (wait_r == 18'h1)
                      state_nxt = pwr_r[BIT_LOW_SPEED] ? ST_SUBACTIVE : ST_ACTIVE;
      default:      state_nxt = ST_ACTIVE;
    endcase
  end

  // waits count only after a wake from an oscillator-stopped state
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r   <= ST_ACTIVE;
      wait_r    <= 18'h0;
      WAIT_DONE <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      WAIT_DONE <= (wait_r == 18'h1);
      if ((state_r == ST_STANDBY || state_r == ST_WATCH) && WAKE_REQ && wait_r == 18'h0)
        wait_r <= wait_len(pwr_r[BIT_WAIT_HI:BIT_WAIT_LO]);
      else if (wait_r != 18'h0)
        wait_r <= 18'(wait_r - 18'h1);
    end
  end

  // cpu clock choice follows the low-speed bit
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) CPU_ON_SUBCLK <= 1'b0;
    else CPU_ON_SUBCLK <= pwr_r[BIT_LOW_SPEED];
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // cycles since the last sample pulse; an aux write restarts the
  // measurement, since the period across a rate change is partial
  logic [4:0] gap_r;        // cycles since the last sample pulse
  logic       rate_held_r;  // no aux write since the last pulse

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gap_r       <= 5'h00;
      rate_held_r <= 1'b0;
    end else begin
      gap_r <= sample_en ? 5'h01 : 5'(gap_r + 5'h01);
      if (wr_en && PADDR == OFF_AUX_CTRL) rate_held_r <= 1'b0;
      else if (sample_en) rate_held_r <= 1'b1;
    end
  end

  // named steps of a sleep from active
  sequence s_sleep_active;
    state_r == ST_ACTIVE && SLEEP_REQ;
  endsequence

  a_active_sleep_target: assert property (@(posedge CLK) disable iff (RST)
    s_sleep_active |=> state_r == ($past(pwr_r[BIT_STANDBY_SEL]) ? ST_STANDBY : ST_SLEEP))
    else $error("wrong state after sleep from active");
  a_sub_sleep_target: assert property (@(posedge CLK) disable iff (RST)
    state_r == ST_SUBACTIVE && SLEEP_REQ |=>
      state_r == ($past(pwr_r[BIT_STANDBY_SEL]) ? ST_WATCH : ST_SUBSLEEP))
    else $error("wrong state after sleep from subactive");
  a_wait_load_len: assert property (@(posedge CLK) disable iff (RST)
    $rose(wait_r != 18'h0) |-> wait_r == wait_len($past(pwr_r[6:4])))
    else $error("settling wait length wrong");
  a_low_speed_out: assert property (@(posedge CLK) disable iff (RST)
    ##1 CPU_ON_SUBCLK == $past(pwr_r[BIT_LOW_SPEED]))
    else $error("cpu clock select mismatch");
  a_noise_period: assert property (@(posedge CLK) disable iff (RST)
    sample_en && rate_held_r |->
      gap_r == (aux_r[BIT_NOISE_SEL] ? 5'(NOISE_DIV_FAST) : 5'(NOISE_DIV_SLOW)))
    else $error("sample pulse period wrong");
  a_pin_flag_clear: assert property (@(posedge CLK) disable iff (RST)
    wr_en && PADDR == OFF_IRQ_FLAGS && flags_r[0] && !PWDATA[0] && !set_vec[0]
      |=> !flags_r[0])
    else $error("pin flag not cleared");
  a_pin_flag_set: assert property (@(posedge CLK) disable iff (RST)
    pin_edge[0] && PIN_IRQ_EN[0] |=> flags_r[0])
    else $error("pin flag not set on edge");
  a_serial_flag_set: assert property (@(posedge CLK) disable iff (RST)
    SRC.serial1_done |=> flags_r[BIT_S1_FLAG])
    else $error("serial flag not set");
  a_timer_flag_clear: assert property (@(posedge CLK) disable iff (RST)
    wr_en && PADDR == OFF_IRQ_FLAGS && flags_r[7] && !PWDATA[7] && !tmr_wrap |=> !flags_r[7])
    else $error("timer flag not cleared");
  a_timer_wrap_set: assert property (@(posedge CLK) disable iff (RST)
    tmr_wrap |=> flags_r[BIT_TA_FLAG] && tmr_r == 8'h00)
    else $error("timer wrap did not set flag");
  a_timer_irq_gate: assert property (@(posedge CLK) disable iff (RST)
    IRQ_TIMER_A |-> $past(aux_r[BIT_TA_IEN]) && $past(flags_r[7]))
    else $error("timer interrupt not gated");
  a_flag_no_sw_set: assert property (@(posedge CLK) disable iff (RST)
    $rose(flags_r[BIT_S1_FLAG]) |-> $past(SRC.serial1_done))
    else $error("flag set without hardware event");

endmodule : pwr_irq_regs

// [tb/pwr_irq_regs_test.sv]
`timescale 1ns/1ns
module pwr_irq_regs_test
  import pwr_irq_pkg::*;
();
  // ------------------------------------------------------------
  // bench signals
  // ------------------------------------------------------------
  logic        clk;                   // 50 ns bench clock
  logic        rst;                   // async reset, high
  logic        psel, penable, pwrite; // apb master side
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr;
  logic        sleep_req, wake_req;   // power requests
  irq_src_t    src;                   // event sources
  logic [4:0]  pin_en, pin_rise;      // edge kind picked at random
  logic        on_sub, wait_done, irq_ta, irq;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } exp_t;                            // one note per bus transfer
  exp_t        exp_q[$];              // notes left by the driver
  int          err_total, checks_done;
  logic [31:0] set_v;                 // flag image with one pin set
  logic [7:0]  rnd_v;                 // random power mode value

  // ------------------------------------------------------------
  // clock and design
  // ------------------------------------------------------------
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // waits shrink to 8..128 cycles so the run stays short
  pwr_irq_regs #(.WAIT_SCALE(1024)) u_pwr_irq_regs (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SLEEP_REQ(sleep_req), .WAKE_REQ(wake_req), .SRC(src),
    .PIN_IRQ_EN(pin_en), .PIN_RISING(pin_rise), .CPU_ON_SUBCLK(on_sub),
    .WAIT_DONE(wait_done), .IRQ_TIMER_A(irq_ta), .IRQ(irq)
  );

  // ------------------------------------------------------------
  // compare tasks and verdict
  // ------------------------------------------------------------
  task cmp_rd(input logic [31:0] got, input logic gerr, input exp_t x);
    checks_done++;
    if (((got & x.m) !== x.d) || (gerr !== x.e)) begin
      err_total++;
      $display("[ERR] %0t bus got %h/%b want %h/%b", $time, got, gerr, x.d, x.e);
    end
  endtask : cmp_rd

  task cmp_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s is %b, want %b", $time, what, got, exp);
    end
  endtask : cmp_bit

  task cmp_cnt(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[ERR] %0t wait took %0d, want %0d..%0d", $time, got, lo, hi);
    end
  endtask : cmp_cnt

  task finish_test();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // apb master; the note is queued before the request goes out
  // ------------------------------------------------------------
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
            input logic [31:0] ed, input logic [31:0] m, input logic e);
    exp_q.push_back('{ed & m, m, e});
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // hold everything until pready is seen; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    xfer(1'b1, a, d, 32'h0, 32'h0, e);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed,
          input logic [31:0] m = 32'hFFFF_FFFF, input logic e = 1'b0);
    xfer(1'b0, a, $urandom, ed, m, e);  // write data is noise on a read
  endtask : rd

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // ------------------------------------------------------------
  // monitor: every completed transfer takes the oldest note
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[ERR] %0t transfer with no note", $time);
      end else begin
        cmp_rd(prdata, pslverr, exp_q.pop_front());
      end
    end
  end

  // one sleep, one wake; n is the settling wait in cycles, 0 for none
  task pwr(input logic [7:0] mode, input logic [2:0] s_in, s_out, input int n);
    int k;
    wr(OFF_PWR_MODE, {24'h0, mode});
    cyc(2);
    cmp_bit(on_sub, mode[3], "subclock");
    @(posedge clk) sleep_req <= 1'b1;
    @(posedge clk) sleep_req <= 1'b0;
    rd(OFF_STATE, {29'h0, s_in});
    @(posedge clk) wake_req <= 1'b1;
    @(posedge clk) wake_req <= 1'b0;
    k = 0;
    while (n > 0 && wait_done !== 1'b1 && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (n > 0) cmp_cnt(k, n, n + 3);
    else cyc(3);
    rd(OFF_STATE, {29'h0, s_out});
  endtask : pwr

  // ------------------------------------------------------------
  // watchdog, far beyond the few thousand cycles of the run
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hD20C));
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; sleep_req = 1'b0; wake_req = 1'b0;
    pin_en = 5'h00; pin_rise = 5'($urandom());
    src = '0;
    src.ext_pins = ~pin_rise;                        // idle at the inactive level
    err_total = 0; checks_done = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // reset values, unmapped place refused
    rd(OFF_PWR_MODE, 32'h0000_0007);
    rd(OFF_IRQ_FLAGS, 32'h0000_0020);
    rd(OFF_STATE, 32'h0);
    wr(8'h18, 32'hFFFF_FFFF, 1'b1);
    rd(8'h18, 32'h0, 32'hFFFF_FFFF, 1'b1);
    wr(OFF_IRQ_FLAGS, 32'h0);                        // zero on clear flags, no effect
    rd(OFF_IRQ_FLAGS, 32'h0000_0020);
    rnd_v = 8'($urandom());
    wr(OFF_PWR_MODE, {24'h0, rnd_v});
    rd(OFF_PWR_MODE, {24'h0, rnd_v & 8'hF8 | 8'h07});
    // timer a: 255 ticks stay short of the wrap, the 256th wraps
    repeat (255) @(posedge clk) src.timer_a_tick <= 1'b1;
    @(posedge clk) src.timer_a_tick <= 1'b0;
    cyc(2);
    rd(OFF_IRQ_FLAGS, 32'h0000_0020);
    @(posedge clk) src.timer_a_tick <= 1'b1;
    @(posedge clk) src.timer_a_tick <= 1'b0;
    cyc(2);
    rd(OFF_IRQ_FLAGS, 32'h0000_00A0);
    cmp_bit(irq_ta, 1'b0, "timer irq");
    wr(OFF_AUX_CTRL, 32'h2);
    cyc(2);
    cmp_bit(irq_ta, 1'b1, "timer irq");
    wr(OFF_IRQ_FLAGS, 32'hFF);
    rd(OFF_IRQ_FLAGS, 32'h0000_00A0);
    wr(OFF_IRQ_FLAGS, 32'h7F);
    rd(OFF_IRQ_FLAGS, 32'h0000_0020);
    cyc(2);
    cmp_bit(irq_ta, 1'b0, "timer irq");
    // serial channel 1 done
    @(posedge clk) src.serial1_done <= 1'b1;
    @(posedge clk) src.serial1_done <= 1'b0;
    cyc(1);
    rd(OFF_IRQ_FLAGS, 32'h0000_0060);
    wr(OFF_IRQ_FLAGS, 32'hBF);
    rd(OFF_IRQ_FLAGS, 32'h0000_0020);
    // pins 0..3 enabled, pin 4 not; only pin 1 uses the fast sample rate
    pin_en <= 5'h0F;
    for (int j = 0; j < 5; j++) begin
      wr(OFF_AUX_CTRL, 32'(j == 1));
      set_v = 32'h20 | (32'h1 << j);
      @(posedge clk) src.ext_pins[j] <= pin_rise[j];
      cyc(12);
      rd(OFF_IRQ_FLAGS, (j == 1) ? set_v : 32'h20);
      cyc(50);
      rd(OFF_IRQ_FLAGS, (j == 4) ? 32'h20 : set_v);
      wr(OFF_IRQ_FLAGS, ~(32'h1 << j) & 32'hFF);
      rd(OFF_IRQ_FLAGS, 32'h0000_0020);
      @(posedge clk) src.ext_pins[j] <= ~pin_rise[j];
      cyc(60);
      rd(OFF_IRQ_FLAGS, 32'h0000_0020);
    end
    // summary interrupt: bit 6 unmasked, exact latency, cleared
    wr(OFF_EVT_STATUS, 32'hFF);
    wr(OFF_EVT_MASK, 32'h40);
    @(posedge clk) src.serial1_done <= 1'b1;
    @(posedge clk) src.serial1_done <= 1'b0;
    @(negedge clk) cmp_bit(irq, 1'b0, "irq early");
    @(negedge clk) cmp_bit(irq, 1'b1, "irq");
    rd(OFF_EVT_STATUS, 32'h40, 32'hDF);
    wr(OFF_EVT_STATUS, 32'h40);
    cyc(2);
    cmp_bit(irq, 1'b0, "irq cleared");
    wr(OFF_IRQ_FLAGS, 32'hBF);
    // power modes and every wait length
    pwr(8'h00, ST_SLEEP, ST_ACTIVE, 0);
    for (int i = 0; i < 8; i++) if (i != 5 && i != 6) begin
      pwr(8'h80 | 8'(i << 4), ST_STANDBY, ST_ACTIVE, 8 << ((i > 4) ? 4 : i));
    end
    pwr(8'h88, ST_STANDBY, ST_SUBACTIVE, 8);
    pwr(8'h08, ST_SUBSLEEP, ST_SUBACTIVE, 0);
    pwr(8'h80, ST_WATCH, ST_ACTIVE, 8);
    cyc(4);
    cmp_cnt(exp_q.size(), 0, 0);
    finish_test();
  end
endmodule : pwr_irq_regs_test
